// >>> inc/framing_pkg.sv
package framing_pkg;

    // Register offsets on the configuration port
    localparam logic [5:0] ADDR_MODEM_CFG2 = 6'h12;
    localparam logic [5:0] ADDR_FRAMING_CFG = 6'h13;
    localparam logic [5:0] ADDR_STEP_FINE = 6'h14;

    // Field positions
    localparam int MANCH_BIT = 3;
    localparam int SYNCMODE_HI = 2;
    localparam int SYNCMODE_LO = 0;
    localparam int FEC_BIT = 7;
    localparam int PREAMBLE_HI = 6;
    localparam int PREAMBLE_LO = 4;
    localparam int RSVD_HI = 3;
    localparam int RSVD_LO = 2;
    localparam int EXP_HI = 1;
    localparam int EXP_LO = 0;

    // Reset values
    localparam logic MANCH_RST = 1'h0;
    localparam logic [2:0] SYNC_MODE_RST = 3'h2;
    localparam logic FEC_RST = 1'h0;
    localparam logic [2:0] PREAMBLE_RST = 3'h2;
    localparam logic [1:0] EXP_RST = 2'h2;
    localparam logic [7:0] MANT_RST = 8'hF8;

    // Framing constants
    localparam logic [7:0] PREAMBLE_PATTERN = 8'hAA;
    localparam logic [7:0] SYNC_BITS_SHORT = 8'h10;
    localparam logic [7:0] SYNC_BITS_LONG = 8'h20;
    localparam logic [5:0] MISS_15OF16 = 6'h01;
    localparam logic [5:0] MISS_30OF32 = 6'h02;
    localparam logic [8:0] MANT_HIDDEN_ONE = 9'h100;

    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_PREAMBLE = 4'b0010,
        TX_SYNC = 4'b0100,
        TX_PAYLOAD = 4'b1000
    } tx_state_type;

    // Preamble byte count for the three-bit selection
    function automatic logic [7:0] preamble_bytes(input logic [2:0] sel);
        case (sel)
            3'h0: preamble_bytes = 8'h02;
            3'h1: preamble_bytes = 8'h03;
            3'h2: preamble_bytes = 8'h04;
            3'h3: preamble_bytes = 8'h06;
            3'h4: preamble_bytes = 8'h08;
            3'h5: preamble_bytes = 8'h0C;
            3'h6: preamble_bytes = 8'h10;
            default: preamble_bytes = 8'h18;
        endcase
    endfunction

    function automatic logic sends_sync(input logic [2:0] mode);
        sends_sync = (mode[1:0] != 2'h0);
    endfunction

    function automatic logic sync_long(input logic [2:0] mode);
        sync_long = (mode[1:0] == 2'h3);
    endfunction

    function automatic logic needs_cs(input logic [2:0] mode);
        needs_cs = mode[2];
    endfunction

endpackage

// >>> inc/sync_det_if.sv
`timescale 1ns/1ps
interface sync_det_if;
    logic rxBit;
    logic rxBitValid;
    logic [15:0] syncWord;
    logic [2:0] syncMode;
    logic flush;
    logic hit;

    modport ctrl(output rxBit, output rxBitValid, output syncWord, output syncMode, output flush, input hit);
    modport corr(input rxBit, input rxBitValid, input syncWord, input syncMode, input flush, output hit);
endinterface

// >>> verilog/sync_correlator.sv
`timescale 1ns/1ps
module sync_correlator (
    input wire logic clk,
    input wire logic rst,
    sync_det_if.corr det
);
    import framing_pkg::*;

    logic [31:0] history_r;
    logic [7:0] fill_r;
    logic fresh_r;
    logic [31:0] target;
    logic [31:0] diff;
    logic [5:0] missLong;
    logic [5:0] missShort;

    function automatic logic [5:0] count_ones(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            n = n + {5'h00, v[i]};
        end
        count_ones = n;
    endfunction

    always_ff @(posedge clk) begin
        if (rst || det.flush) begin
            history_r <= 32'h0000_0000;
            fill_r <= 8'h00;
        end else if (det.rxBitValid) begin
            history_r <= {history_r[30:0], det.rxBit};
            if (fill_r != SYNC_BITS_LONG) begin
                fill_r <= fill_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fresh_r <= 1'b0;
        end else begin
            fresh_r <= det.rxBitValid && !det.flush;
        end
    end

    assign target = {det.syncWord, det.syncWord};
    assign diff = history_r ^ target;
    assign missLong = count_ones(diff);
    assign missShort = count_ones({16'h0000, diff[15:0]});

    always_comb begin
        det.hit = 1'b0;
        if (fresh_r && sends_sync(det.syncMode)) begin
            if (sync_long(det.syncMode)) begin
                det.hit = (fill_r >= SYNC_BITS_LONG) && (missLong <= MISS_30OF32);
            end else if (det.syncMode[1:0] == 2'h1) begin
                det.hit = (fill_r >= SYNC_BITS_SHORT) && (missShort <= MISS_15OF16);
            end else begin
                det.hit = (fill_r >= SYNC_BITS_SHORT) && (missShort == 6'h00);
            end
        end
    end

    exact_match_a: assert property (@(posedge clk) disable iff (rst)
        det.hit && det.syncMode[1:0] == 2'h2 |-> history_r[15:0] == det.syncWord)
        else $error("16 of 16 sync hit with mismatched bits");
    long_match_a: assert property (@(posedge clk) disable iff (rst)
        det.hit && det.syncMode[1:0] == 2'h3 |-> fill_r == SYNC_BITS_LONG && count_ones(diff) <= 6'h02)
        else $error("32 bit sync hit beyond two errors");
    no_search_a: assert property (@(posedge clk) disable iff (rst)
        det.syncMode[1:0] == 2'h0 |-> !det.hit)
        else $error("sync hit while search is off");
endmodule

// >>> verilog/channel_index_offset_calc.sv
`timescale 1ns/1ps
module channel_index_offset_calc #(
    parameter int CHANNEL_INDEX_W = 8
) (
    input wire logic [7:0] mantissa,
    input wire logic [1:0] exponent,
    input wire logic [CHANNEL_INDEX_W-1:0] channel,
    output logic [CHANNEL_INDEX_W+11:0] offset
);
    import framing_pkg::*;

    logic [11:0] step;

    // Step in units of the crystal frequency over 2^18
    assign step = {3'h0, MANT_HIDDEN_ONE + {1'b0, mantissa}} << exponent;
    assign offset = step * channel;
endmodule

// >>> verilog/sync_preamble_chanspace_cfg.sv
`timescale 1ns/1ps
module sync_preamble_chanspace_cfg #(
    parameter int CHANNEL_INDEX_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic [15:0] syncWord,
    input wire logic [CHANNEL_INDEX_W-1:0] channelIndex,
    input wire logic carrierSense,
    input wire logic rxSearchEn,
    input wire logic rxBit,
    input wire logic rxBitValid,
    input wire logic txStart,
    input wire logic txStop,
    input wire logic txBitTick,
    input wire logic txPayloadBit,
    output logic txBitOut,
    output logic txBitValid,
    output logic txPayloadPhase,
    output logic fecActive,
    output logic manchesterOn,
    output logic rxSyncFound,
    output logic rxQualified,
    output logic [CHANNEL_INDEX_W+11:0] chanOffset
);
    import framing_pkg::*;

    logic manch_r;
    logic [2:0] syncMode_r;
    logic fecEn_r;
    logic [2:0] preSel_r;
    logic [1:0] chanExp_r;
    logic [7:0] chanMant_r;
    logic cs_r;
    tx_state_type txState_r;
    tx_state_type txState_nxt;
    logic [2:0] txMode_r;
    logic [2:0] txPre_r;
    logic [7:0] bitCnt_r;
    logic [7:0] bitCnt_nxt;
    logic [7:0] preSent_r;
    logic [CHANNEL_INDEX_W+11:0] offsetNow;
    logic syncHit;
    logic qualHit;
    sync_det_if det();

    // Configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            manch_r <= MANCH_RST;
            syncMode_r <= SYNC_MODE_RST;
        end else if (regWrEn && regAddr == ADDR_MODEM_CFG2) begin
            manch_r <= regWrData[MANCH_BIT];
            syncMode_r <= regWrData[SYNCMODE_HI:SYNCMODE_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fecEn_r <= FEC_RST;
            preSel_r <= PREAMBLE_RST;
            chanExp_r <= EXP_RST;
        end else if (regWrEn && regAddr == ADDR_FRAMING_CFG) begin
            fecEn_r <= regWrData[FEC_BIT];
            preSel_r <= regWrData[PREAMBLE_HI:PREAMBLE_LO];
            chanExp_r <= regWrData[EXP_HI:EXP_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            chanMant_r <= MANT_RST;
        end else if (regWrEn && regAddr == ADDR_STEP_FINE) begin
            chanMant_r <= regWrData;
        end
    end

    // Read path, one cycle behind the address
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else begin
            case (regAddr)
                ADDR_MODEM_CFG2: regRdData <= {4'h0, manch_r, syncMode_r};
                ADDR_FRAMING_CFG: regRdData <= {fecEn_r, preSel_r, 2'h0, chanExp_r};
                ADDR_STEP_FINE: regRdData <= chanMant_r;
                default: regRdData <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_r <= 1'b0;
        end else begin
            cs_r <= carrierSense;
        end
    end

    // Transmit sequencer: preamble, sync, payload
    always_comb begin
        txState_nxt = txState_r;
        bitCnt_nxt = bitCnt_r;
        case (txState_r)
            TX_IDLE: begin
                if (txStart) begin
                    if (syncMode_r == 3'h0) begin
                        txState_nxt = TX_PAYLOAD;
                    end else begin
                        txState_nxt = TX_PREAMBLE;
                        bitCnt_nxt = preamble_bytes(preSel_r) << 3;
                    end
                end
            end
            TX_PREAMBLE: begin
                if (txBitTick) begin
                    bitCnt_nxt = bitCnt_r - 8'h01;
                    if (bitCnt_r == 8'h01) begin
                        if (sends_sync(txMode_r)) begin
                            txState_nxt = TX_SYNC;
                            bitCnt_nxt = sync_long(txMode_r) ? SYNC_BITS_LONG : SYNC_BITS_SHORT;
                        end else begin
                            txState_nxt = TX_PAYLOAD;
                        end
                    end
                end
            end
            TX_SYNC: begin
                if (txBitTick) begin
                    bitCnt_nxt = bitCnt_r - 8'h01;
                    if (bitCnt_r == 8'h01) begin
                        txState_nxt = TX_PAYLOAD;
                    end
                end
            end
            TX_PAYLOAD: begin
                if (txStop) begin
                    txState_nxt = TX_IDLE;
                end
            end
            default: begin
                txState_nxt = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txState_r <= TX_IDLE;
            bitCnt_r <= 8'h00;
        end else begin
            txState_r <= txState_nxt;
            bitCnt_r <= bitCnt_nxt;
        end
    end

    // Mode and preamble length held for the whole frame
    always_ff @(posedge clk) begin
        if (rst) begin
            txMode_r <= SYNC_MODE_RST;
            txPre_r <= PREAMBLE_RST;
        end else if (txState_r == TX_IDLE && txStart) begin
            txMode_r <= syncMode_r;
            txPre_r <= preSel_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txBitOut <= 1'b0;
            txBitValid <= 1'b0;
        end else begin
            txBitValid <= 1'b0;
            if (txBitTick) begin
                case (txState_r)
                    TX_PREAMBLE: begin
                        txBitOut <= PREAMBLE_PATTERN[3'(bitCnt_r - 8'h01)];
                        txBitValid <= 1'b1;
                    end
                    TX_SYNC: begin
                        txBitOut <= syncWord[4'(bitCnt_r - 8'h01)];
                        txBitValid <= 1'b1;
                    end
                    TX_PAYLOAD: begin
                        txBitOut <= txPayloadBit;
                        txBitValid <= 1'b1;
                    end
                    default: begin
                        txBitOut <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txPayloadPhase <= 1'b0;
            fecActive <= 1'b0;
            manchesterOn <= MANCH_RST;
        end else begin
            txPayloadPhase <= (txState_nxt == TX_PAYLOAD);
            fecActive <= fecEn_r && (txState_nxt == TX_PAYLOAD);
            manchesterOn <= manch_r;
        end
    end

    // Preamble bit tally for the current frame
    always_ff @(posedge clk) begin
        if (rst || txState_r == TX_IDLE) begin
            preSent_r <= 8'h00;
        end else if (txState_r == TX_PREAMBLE && txBitTick) begin
            preSent_r <= preSent_r + 8'h01;
        end
    end

    // Receive sync search
    assign det.rxBit = rxBit;
    assign det.rxBitValid = rxBitValid && rxSearchEn;
    assign det.syncWord = syncWord;
    assign det.syncMode = syncMode_r;
    assign det.flush = !rxSearchEn;
    assign syncHit = det.hit;

    sync_correlator u_corr (
        .clk(clk),
        .rst(rst),
        .det(det.corr)
    );

    always_comb begin
        qualHit = 1'b0;
        if (!sends_sync(syncMode_r)) begin
            qualHit = (syncMode_r == 3'h4) && cs_r;
        end else begin
            qualHit = syncHit && (!needs_cs(syncMode_r) || cs_r);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rxSyncFound <= 1'b0;
            rxQualified <= 1'b0;
        end else begin
            rxSyncFound <= rxSearchEn && qualHit;
            rxQualified <= rxSearchEn && (rxQualified || qualHit);
        end
    end

    channel_index_offset_calc #(
        .CHANNEL_INDEX_W(CHANNEL_INDEX_W)
    ) u_offset (
        .mantissa(chanMant_r),
        .exponent(chanExp_r),
        .channel(channelIndex),
        .offset(offsetNow)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            chanOffset <= '0;
        end else begin
            chanOffset <= offsetNow;
        end
    end

    sync_mode_reset_a: assert property (@(posedge clk)
        $past(rst) && !rst |-> syncMode_r == 3'h2 && chanExp_r == 2'h2)
        else $error("configuration reset values wrong");
    mantissa_reset_a: assert property (@(posedge clk)
        $past(rst) && !rst |-> chanMant_r == 8'hF8)
        else $error("spacing mantissa reset value wrong");
    no_sync_tx_a: assert property (@(posedge clk) disable iff (rst)
        txState_r == TX_SYNC |-> txMode_r[1:0] != 2'h0)
        else $error("sync sent in a no-sync mode");
    preamble_length_a: assert property (@(posedge clk) disable iff (rst)
        txState_r == TX_PREAMBLE && txState_nxt != TX_PREAMBLE
        |=> preSent_r == (preamble_bytes(txPre_r) << 3))
        else $error("preamble length differs from selection");
    sync_length_a: assert property (@(posedge clk) disable iff (rst)
        txState_r == TX_PREAMBLE ##1 txState_r == TX_SYNC |-> bitCnt_r == (sync_long(txMode_r) ? 8'h20 : 8'h10))
        else $error("sync length wrong for mode");
    cs_gate_a: assert property (@(posedge clk) disable iff (rst)
        rxSyncFound && $past(syncMode_r[2]) |-> $past(cs_r))
        else $error("sync qualified without carrier sense");
    fec_payload_a: assert property (@(posedge clk) disable iff (rst)
        fecActive |-> txPayloadPhase && $past(fecEn_r))
        else $error("FEC active outside payload");
    reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
        $past(regAddr) == ADDR_FRAMING_CFG && !$past(rst) |-> regRdData[3:2] == 2'h0)
        else $error("reserved bits read non-zero");
    offset_value_a: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> chanOffset == 20'(((32'($past(chanMant_r)) + 32'd256) << $past(chanExp_r))
        * 32'($past(channelIndex))))
        else $error("channel offset mismatch");
    manchester_a: assert property (@(posedge clk) disable iff (rst)
        regWrEn && regAddr == ADDR_MODEM_CFG2 |-> ##2 manchesterOn == $past(regWrData[3], 2))
        else $error("manchester flag not following register");
endmodule

// >>> sim/radio_peer.sv
`timescale 1ns/1ps
module radio_peer (
    input wire logic clk,
    input wire logic go,
    input wire logic [47:0] frame,
    input wire logic [5:0] nBits,
    output logic rxBit,
    output logic rxBitValid,
    output logic busy
);
    logic [47:0] shiftR;
    logic [5:0] leftR;
    logic [1:0] gapR;

    initial begin
        rxBit = 1'b0;
        rxBitValid = 1'b0;
        busy = 1'b0;
        shiftR = 48'h0;
        leftR = 6'h00;
        gapR = 2'h0;
    end

    // Bits leave MSB first, one every third cycle; between bits the line flips so stale data never looks valid
    always @(posedge clk) begin
        #2;
        rxBitValid = 1'b0;
        rxBit = ~rxBit;
        if (go && !busy) begin
            shiftR = frame << (7'd48 - {1'b0, nBits});
            leftR = nBits;
            gapR = 2'h0;
            busy = (nBits != 6'h00);
        end else if (busy) begin
            if (gapR == 2'h0) begin
                rxBit = shiftR[47];
                rxBitValid = 1'b1;
                shiftR = shiftR << 1;
                leftR = leftR - 6'h01;
                busy = (leftR != 6'h00);
            end
            gapR = (gapR == 2'h2) ? 2'h0 : gapR + 2'h1;
        end
    end
endmodule

// >>> sim/tb_sync_preamble_chanspace_cfg.sv
`timescale 1ns/1ps
module tb_sync_preamble_chanspace_cfg;
    import framing_pkg::*;
    localparam int LIMIT = 20000;
    localparam logic [15:0] WORD = 16'hD391;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] regAddr = 6'h00;
    logic regWrEn = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic [7:0] channelIndex = 8'h00;
    logic carrierSense = 1'b0;
    logic rxSearchEn = 1'b0;
    logic rxBit, rxBitValid, busy;
    logic txStart = 1'b0;
    logic txStop = 1'b0;
    logic txBitTick = 1'b0;
    logic payBit = 1'b0;
    logic txBitOut, txBitValid, txPayloadPhase, fecActive, manchesterOn, rxSyncFound, rxQualified;
    logic [19:0] chanOffset;
    logic go = 1'b0;
    logic [47:0] frame = 48'h0;
    logic [5:0] nBits = 6'h00;
    logic syncSeen = 1'b0;
    logic txQ[$];
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    sync_preamble_chanspace_cfg #(.CHANNEL_INDEX_W(8)) dut (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdData(regRdData), .syncWord(WORD), .channelIndex(channelIndex), .carrierSense(carrierSense),
        .rxSearchEn(rxSearchEn), .rxBit(rxBit), .rxBitValid(rxBitValid), .txStart(txStart), .txStop(txStop),
        .txBitTick(txBitTick), .txPayloadBit(payBit), .txBitOut(txBitOut), .txBitValid(txBitValid),
        .txPayloadPhase(txPayloadPhase), .fecActive(fecActive), .manchesterOn(manchesterOn),
        .rxSyncFound(rxSyncFound), .rxQualified(rxQualified), .chanOffset(chanOffset)
    );

    radio_peer peer (.clk(clk), .go(go), .frame(frame), .nBits(nBits), .rxBit(rxBit),
        .rxBitValid(rxBitValid), .busy(busy));

    task automatic finish_test;
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            errors++;
        end
    endtask

    always @(posedge clk) begin
        if (txBitValid === 1'b1) txQ.push_back(txBitOut);
        if (rxSyncFound === 1'b1) syncSeen = 1'b1;
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            finish_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        step(1);
        regWrEn = 1'b0;
        // Let an edge pass so a following write never toggles the strobe within one time step
        step(1);
    endtask

    task automatic reg_check(input logic [5:0] a, input logic [7:0] exp);
        regAddr = a;
        step(2);
        check("regRdData", 32'(regRdData), 32'(exp));
    endtask

    task automatic test_reset_values;
        reg_check(ADDR_MODEM_CFG2, 8'h02);
        reg_check(ADDR_FRAMING_CFG, 8'h22);
        reg_check(ADDR_STEP_FINE, 8'hF8);
        check("manchesterOn", 32'(manchesterOn), 32'h0);
    endtask

    task automatic test_reg_fields;
        reg_write(ADDR_MODEM_CFG2, 8'hFB);
        reg_check(ADDR_MODEM_CFG2, 8'h0B);
        check("manchesterOn", 32'(manchesterOn), 32'h1);
        reg_write(ADDR_MODEM_CFG2, 8'h02);
        step(2);
        check("manchesterOn", 32'(manchesterOn), 32'h0);
        reg_write(ADDR_FRAMING_CFG, 8'hFF);
        reg_check(ADDR_FRAMING_CFG, 8'hF3);
        reg_write(6'h15, 8'h5A);
        reg_check(6'h15, 8'h00);
        reg_check(ADDR_STEP_FINE, 8'hF8);
    endtask

    task automatic test_channel_index_offset;
        logic [7:0] mv[4] = '{8'h00, 8'h7F, 8'hFF, 8'hF8};
        logic [7:0] cv[4] = '{8'h00, 8'h01, 8'hFF, 8'h80};
        int i;
        for (i = 0; i < 4; i++) begin
            reg_write(ADDR_STEP_FINE, mv[i]);
            reg_write(ADDR_FRAMING_CFG, {6'h08, 2'(i)});
            channelIndex = cv[i];
            step(3);
            check("chanOffset", 32'(chanOffset), ((32'h100 + 32'(mv[i])) << i) * 32'(cv[i]));
        end
    endtask

    task automatic tx_frame(input logic [2:0] mode);
        int pb[8] = '{2, 3, 4, 6, 8, 12, 16, 24};
        int nb, ns, i, k;
        nb = (mode == 3'h0) ? 0 : pb[mode] * 8;
        ns = (mode[1:0] == 2'h0) ? 0 : ((mode[1:0] == 2'h3) ? 32 : 16);
        reg_write(ADDR_MODEM_CFG2, {5'h00, mode});
        reg_write(ADDR_FRAMING_CFG, {1'b1, mode, 4'h2});
        txQ.delete();
        txStart = 1'b1;
        step(1);
        txStart = 1'b0;
        step(1);
        for (k = 0; k < 300 && txPayloadPhase !== 1'b1; k++) begin
            if (k == 1) check("fecActive", 32'(fecActive), 32'h0);
            txBitTick = 1'b1;
            step(1);
            txBitTick = 1'b0;
            step(2);
        end
        step(3);
        check("txBits", 32'(txQ.size()), 32'(nb + ns));
        for (i = 0; i < nb + ns && i < txQ.size(); i++) begin
            check("txBitOut", 32'(txQ[i]), 32'(i < nb ? (i % 2 == 0) : WORD[15 - ((i - nb) % 16)]));
        end
        check("fecActive", 32'(fecActive), 32'h1);
        payBit = !mode[0];
        txBitTick = 1'b1;
        step(1);
        txBitTick = 1'b0;
        step(2);
        check("txPayloadBit", 32'(txQ[txQ.size() - 1]), 32'(!mode[0]));
        txStop = 1'b1;
        step(1);
        txStop = 1'b0;
        step(2);
        check("txPayloadPhase", 32'(txPayloadPhase), 32'h0);
        check("fecActive", 32'(fecActive), 32'h0);
    endtask

    task automatic test_tx_modes;
        int m;
        for (m = 0; m < 8; m++) tx_frame(3'(m));
    endtask

    task automatic rx_case(input logic [2:0] mode, input logic cs, input logic [47:0] f, input logic [5:0] n,
            input logic exp);
        int k;
        reg_write(ADDR_MODEM_CFG2, {5'h00, mode});
        carrierSense = cs;
        rxSearchEn = 1'b1;
        syncSeen = 1'b0;
        frame = f;
        nBits = n;
        go = 1'b1;
        step(1);
        go = 1'b0;
        for (k = 0; k < 200 && (busy || k < 6); k++) step(1);
        // The last bit is taken one edge later and the found pulse comes on the edge after that
        step(3);
        check("rxSyncFound", 32'(syncSeen), 32'(exp));
        check("rxQualified", 32'(rxQualified), 32'(exp));
        rxSearchEn = 1'b0;
        carrierSense = 1'b0;
        step(3);
        check("rxQualified", 32'(rxQualified), 32'h0);
    endtask

    task automatic test_rx_modes;
        rx_case(3'h1, 1'b0, {24'h0, 8'hAA, WORD ^ 16'h0010}, 6'd24, 1'b1);
        rx_case(3'h1, 1'b0, {24'h0, 8'hAA, WORD ^ 16'h0110}, 6'd24, 1'b0);
        rx_case(3'h2, 1'b0, {24'h0, 8'hAA, WORD ^ 16'h8000}, 6'd24, 1'b0);
        rx_case(3'h2, 1'b0, {24'h0, 8'hAA, WORD}, 6'd24, 1'b1);
        rx_case(3'h3, 1'b0, {8'h0, 8'hAA, WORD ^ 16'h0100, WORD ^ 16'h0001}, 6'd40, 1'b1);
        rx_case(3'h3, 1'b0, {8'h0, 8'hAA, WORD ^ 16'h0102, WORD ^ 16'h0001}, 6'd40, 1'b0);
        rx_case(3'h0, 1'b1, {24'h0, 8'hAA, WORD}, 6'd24, 1'b0);
        rx_case(3'h4, 1'b1, {24'h0, 8'hAA, 16'h1234}, 6'd24, 1'b1);
        rx_case(3'h4, 1'b0, {24'h0, 8'hAA, WORD}, 6'd24, 1'b0);
        rx_case(3'h5, 1'b0, {24'h0, 8'hAA, WORD ^ 16'h0004}, 6'd24, 1'b0);
        rx_case(3'h5, 1'b1, {24'h0, 8'hAA, WORD ^ 16'h0004}, 6'd24, 1'b1);
        rx_case(3'h6, 1'b0, {24'h0, 8'hAA, WORD}, 6'd24, 1'b0);
        rx_case(3'h7, 1'b1, {8'h0, 8'hAA, WORD ^ 16'h0800, WORD ^ 16'h0040}, 6'd40, 1'b1);
    endtask

    initial begin
        step(2);
        rst = 1'b0;
        test_reset_values();
        test_reg_fields();
        test_channel_index_offset();
        test_tx_modes();
        test_rx_modes();
        finish_test();
    end
endmodule
